// ===== logic/srm_relay.sv
// Status relay mode logic: APB registers, per-contact mode select, relay drive.
// Assumes condition flags and input values arrive from outside the mclk domain.
//
// Chosen here: register access over APB and the register addresses.

// Functional notes
// - Started mode: contacts leave rest while any appliance controller runs.
// - High temp mode: contacts leave rest while any high temperature alarm.
// - No alert mode: contacts leave rest only when no alerts anywhere.
// - Appliance process control mode: leave rest while any controller in process control.
// - Controller process control mode: follow only the connected controller.
// - Temp trip mode: leave rest when temperature input rises above setpoint.
// - Input trip mode: leave rest when general input exceeds setpoint.
// - Purge mode: contacts leave rest while connected controller purges.
// - Trips release only below setpoint less deadband.
module srm_relay
    import srm_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 rst,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 any_running,
    input  wire logic                 any_high_temp,
    input  wire logic                 any_alert,
    input  wire logic                 any_proc_ctrl,
    input  wire logic                 ctrl_proc_ctrl,
    input  wire logic                 ctrl_purging,
    input  wire logic [SRM_VAL_W-1:0] temp_value,
    input  wire logic [SRM_VAL_W-1:0] input_value,
    output logic                      nc_contact_closed,
    output logic                      no_contact_closed
);

    // Condition flags pass a two-stage synchroniser.
    logic [5:0]           flag_s1_q;
    logic [5:0]           flag_s2_q;
    logic [SRM_VAL_W-1:0] temp_s1_q;
    logic [SRM_VAL_W-1:0] temp_s2_q;
    logic [SRM_VAL_W-1:0] in_s1_q;
    logic [SRM_VAL_W-1:0] in_s2_q;
    logic [SRM_VAL_W-1:0] temp_s3_q;
    logic [SRM_VAL_W-1:0] in_s3_q;
    logic [SRM_VAL_W-1:0] temp_good_q, temp_good_d;
    logic [SRM_VAL_W-1:0] in_good_q, in_good_d;

    logic [31:0]          cfg_q, cfg_d;
    logic [15:0]          tsp_q, tsp_d, tdb_q, tdb_d;
    logic [15:0]          isp_q, isp_d, idb_q, idb_d;
    logic [31:0]          rdata_q, rdata_d;
    logic                 nc_active_q, nc_active_d;
    logic                 no_active_q, no_active_d;
    logic                 temp_trip;
    logic                 in_trip;
    logic                 wr_en;
    logic                 rd_en;

    // Tells whether a contact in the given mode should leave its resting state.
    function automatic logic mode_active(input logic [3:0] mode, input logic [5:0] f,
                                         input logic tt, input logic it);
        logic act;
        act = 1'b0;
        case (srm_mode_t'(mode))
            SRM_MODE_STARTED:   act = f[0];
            SRM_MODE_HIGH_TEMP: act = f[1];
            SRM_MODE_NO_ALERT:  act = !f[2];
            SRM_MODE_APP_PC:    act = f[3];
            SRM_MODE_CTRL_PC:   act = f[4];
            SRM_MODE_TEMP_TRIP: act = tt;
            SRM_MODE_IN_TRIP:   act = it;
            SRM_MODE_PURGE:     act = f[5];
            default:            act = 1'b0;
        endcase
        return act;
    endfunction : mode_active

    // True for a word-aligned address inside the register map.
    function automatic logic addr_ok(input logic [11:0] a);
        return (a <= SRM_STATUS_OFF) && (a[1:0] == 2'b00);
    endfunction : addr_ok

    always_ff @(posedge mclk) begin
        if (rst) begin
            flag_s1_q <= 6'h00;
            flag_s2_q <= 6'h00;
            temp_s1_q <= 16'h0000;
            temp_s2_q <= 16'h0000;
            in_s1_q   <= 16'h0000;
            in_s2_q   <= 16'h0000;
            temp_s3_q <= 16'h0000;
            in_s3_q   <= 16'h0000;
        end else begin
            flag_s1_q <= {ctrl_purging, ctrl_proc_ctrl, any_proc_ctrl,
                          any_alert, any_high_temp, any_running};
            flag_s2_q <= flag_s1_q;
            temp_s1_q <= temp_value;
            temp_s2_q <= temp_s1_q;
            in_s1_q   <= input_value;
            in_s2_q   <= in_s1_q;
            temp_s3_q <= temp_s2_q;
            in_s3_q   <= in_s2_q;
        end
    end

    // A measured word is trusted only when two synchronised samples agree, so a word
    // torn by the clock crossing never reaches a trip comparator.
    always_comb begin
        temp_good_d = (temp_s2_q == temp_s3_q) ? temp_s2_q : temp_good_q;
        in_good_d   = (in_s2_q == in_s3_q) ? in_s2_q : in_good_q;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            temp_good_q <= 16'h0000;
            in_good_q   <= 16'h0000;
        end else begin
            temp_good_q <= temp_good_d;
            in_good_q   <= in_good_d;
        end
    end

    srm_trip u_temp_trip (
        .mclk     (mclk),
        .rst      (rst),
        .value    (temp_good_d),
        .setpoint (tsp_q),
        .deadband (tdb_q),
        .tripped  (temp_trip)
    );

    srm_trip u_in_trip (
        .mclk     (mclk),
        .rst      (rst),
        .value    (in_good_d),
        .setpoint (isp_q),
        .deadband (idb_q),
        .tripped  (in_trip)
    );

    // Zero-wait slave: every access completes in its first access cycle.
    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite && addr_ok(paddr);
    assign rd_en   = psel && !penable && !pwrite;
    assign pslverr = psel && penable && !addr_ok(paddr);

    always_comb begin
        cfg_d   = cfg_q;
        tsp_d   = tsp_q;
        tdb_d   = tdb_q;
        isp_d   = isp_q;
        idb_d   = idb_q;
        rdata_d = rdata_q;
        if (wr_en) begin
            case (paddr)
                SRM_CFG_OFF:     cfg_d = {24'h000000, pwdata[7:0]};
                SRM_TEMP_SP_OFF: tsp_d = pwdata[15:0];
                SRM_TEMP_DB_OFF: tdb_d = pwdata[15:0];
                SRM_IN_SP_OFF:   isp_d = pwdata[15:0];
                SRM_IN_DB_OFF:   idb_d = pwdata[15:0];
                default:         cfg_d = cfg_q;
            endcase
        end
        // Read data is captured in the setup cycle so it is stable at the access edge.
        if (rd_en) begin
            case (paddr)
                SRM_CFG_OFF:     rdata_d = cfg_q;
                SRM_TEMP_SP_OFF: rdata_d = {16'h0000, tsp_q};
                SRM_TEMP_DB_OFF: rdata_d = {16'h0000, tdb_q};
                SRM_IN_SP_OFF:   rdata_d = {16'h0000, isp_q};
                SRM_IN_DB_OFF:   rdata_d = {16'h0000, idb_q};
                SRM_STATUS_OFF:  rdata_d = {28'h0000000, in_trip, temp_trip,
                                            no_active_q, nc_active_q};
                default:         rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        nc_active_d = mode_active(cfg_q[SRM_NC_MODE_LSB +: SRM_MODE_W],
                                  flag_s2_q, temp_trip, in_trip);
        no_active_d = mode_active(cfg_q[SRM_NO_MODE_LSB +: SRM_MODE_W],
                                  flag_s2_q, temp_trip, in_trip);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cfg_q       <= SRM_CFG_RST;
            tsp_q       <= SRM_SP_RST;
            tdb_q       <= SRM_DB_RST;
            isp_q       <= SRM_SP_RST;
            idb_q       <= SRM_DB_RST;
            rdata_q     <= 32'h0000_0000;
            nc_active_q <= 1'b0;
            no_active_q <= 1'b0;
        end else begin
            cfg_q       <= cfg_d;
            tsp_q       <= tsp_d;
            tdb_q       <= tdb_d;
            isp_q       <= isp_d;
            idb_q       <= idb_d;
            rdata_q     <= rdata_d;
            nc_active_q <= nc_active_d;
            no_active_q <= no_active_d;
        end
    end

    assign prdata            = rdata_q;
    // Normally closed contact opens when active; normally open one closes.
    assign nc_contact_closed = !nc_active_q;
    assign no_contact_closed = no_active_q;

endmodule : srm_relay

// ===== inc/srm_pkg.sv
// Package for the status relay mode logic: register map, field layout, modes.
// Assumes a 32-bit APB slave on mclk and a synchronous active-high reset.
package srm_pkg;

    // Register byte offsets.
    localparam logic [11:0] SRM_CFG_OFF      = 12'h000;
    localparam logic [11:0] SRM_TEMP_SP_OFF  = 12'h004;
    localparam logic [11:0] SRM_TEMP_DB_OFF  = 12'h008;
    localparam logic [11:0] SRM_IN_SP_OFF    = 12'h00C;
    localparam logic [11:0] SRM_IN_DB_OFF    = 12'h010;
    localparam logic [11:0] SRM_STATUS_OFF   = 12'h014;

    // Configuration fields: mode of each contact.
    localparam int SRM_NC_MODE_LSB = 0;
    localparam int SRM_NO_MODE_LSB = 4;
    localparam int SRM_MODE_W      = 4;

    // Status fields.
    localparam int SRM_ST_NC_OPEN   = 0;
    localparam int SRM_ST_NO_CLOSED = 1;
    localparam int SRM_ST_TEMP_TRIP = 2;
    localparam int SRM_ST_IN_TRIP   = 3;

    // Measured value width and reset values.
    localparam int          SRM_VAL_W     = 16;
    localparam logic [31:0] SRM_CFG_RST   = 32'h0000_0000;
    localparam logic [15:0] SRM_SP_RST    = 16'hFFFF;
    localparam logic [15:0] SRM_DB_RST    = 16'h0000;

    typedef enum logic [3:0] {
        SRM_MODE_DISABLED  = 4'h0,
        SRM_MODE_STARTED   = 4'h1,
        SRM_MODE_HIGH_TEMP = 4'h2,
        SRM_MODE_NO_ALERT  = 4'h3,
        SRM_MODE_APP_PC    = 4'h4,
        SRM_MODE_CTRL_PC   = 4'h5,
        SRM_MODE_TEMP_TRIP = 4'h6,
        SRM_MODE_IN_TRIP   = 4'h7,
        SRM_MODE_PURGE     = 4'h8
    } srm_mode_t;

endpackage : srm_pkg

// ===== logic/srm_trip.sv
// Setpoint trip detector with deadband hysteresis.
// Assumes the value, setpoint and deadband are stable in the mclk domain.
module srm_trip
    import srm_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 rst,
    input  wire logic [SRM_VAL_W-1:0] value,
    input  wire logic [SRM_VAL_W-1:0] setpoint,
    input  wire logic [SRM_VAL_W-1:0] deadband,
    output logic                      tripped
);

    logic                 trip_q;
    logic                 trip_d;
    logic [SRM_VAL_W:0]   release_lvl;

    always_comb begin
        // Setpoint less deadband; a borrow means a deadband above the setpoint never releases.
        release_lvl = {1'b0, setpoint} - {1'b0, deadband};
        trip_d      = trip_q;
        if (!trip_q && value > setpoint) begin
            trip_d = 1'b1;
        end else if (trip_q && !release_lvl[SRM_VAL_W]
                     && value < release_lvl[SRM_VAL_W-1:0]) begin
            trip_d = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            trip_q <= 1'b0;
        end else begin
            trip_q <= trip_d;
        end
    end

    assign tripped = trip_q;

endmodule : srm_trip

// ===== testbench/srm_relay_monitor.sv
// Checker for the two contact outputs against the mode held for each contact.
// Assumes it is bound to srm_relay and mirrors the mode register from APB writes.
module srm_relay_monitor
    import srm_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        any_running,
    input wire logic        any_high_temp,
    input wire logic        any_alert,
    input wire logic        any_proc_ctrl,
    input wire logic        ctrl_proc_ctrl,
    input wire logic        ctrl_purging,
    input wire logic        nc_contact_closed,
    input wire logic        no_contact_closed
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] nc_m_q;
    logic [3:0] no_m_q;
    always_ff @(posedge mclk) begin
        if (rst) begin
            nc_m_q <= 4'h0;
            no_m_q <= 4'h0;
        end else if (psel && penable && pwrite && paddr == 12'h000) begin
            nc_m_q <= pwdata[3:0];
            no_m_q <= pwdata[7:4];
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // A mode and a flag both held still across the synchroniser fix the contact.
    property p_mode(logic [3:0] m, logic [3:0] c, logic f, logic o);
        ((m == c) && $stable(f)) [*5] |-> o == f;
    endproperty
    a_started_nc: assert property (p_mode(nc_m_q, SRM_MODE_STARTED, any_running,
                                          !nc_contact_closed))
        else $error("started mode contact wrong");
    a_hitemp_no: assert property (p_mode(no_m_q, SRM_MODE_HIGH_TEMP, any_high_temp,
                                         no_contact_closed))
        else $error("high temp mode contact wrong");
    a_noalert_nc: assert property (p_mode(nc_m_q, SRM_MODE_NO_ALERT, any_alert,
                                          nc_contact_closed))
        else $error("no alert mode contact wrong");
    a_app_pc_no: assert property (p_mode(no_m_q, SRM_MODE_APP_PC, any_proc_ctrl,
                                         no_contact_closed))
        else $error("appliance control mode contact wrong");
    a_ctrl_pc_nc: assert property (p_mode(nc_m_q, SRM_MODE_CTRL_PC, ctrl_proc_ctrl,
                                          !nc_contact_closed))
        else $error("controller control mode contact wrong");
    a_purge_no: assert property (p_mode(no_m_q, SRM_MODE_PURGE, ctrl_purging,
                                        no_contact_closed))
        else $error("purge mode contact wrong");
    a_off_nc_rest: assert property ((nc_m_q == 4'h0 || nc_m_q > 4'h8) [*2]
                                    |-> nc_contact_closed)
        else $error("disabled closed contact moved");
    a_off_no_rest: assert property ((no_m_q == 4'h0 || no_m_q > 4'h8) [*2]
                                    |-> !no_contact_closed)
        else $error("disabled open contact moved");
    a_reset_rest: assert property (disable iff (1'h0) rst
                                   |=> nc_contact_closed && !no_contact_closed)
        else $error("contacts not at rest in reset");
    cover property (nc_m_q == SRM_MODE_TEMP_TRIP && !nc_contact_closed);
    cover property (no_m_q == SRM_MODE_IN_TRIP && no_contact_closed);
    cover property (no_m_q == SRM_MODE_PURGE && no_contact_closed);
endmodule : srm_relay_monitor

bind srm_relay srm_relay_monitor u_mon (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .any_running(any_running),
    .any_high_temp(any_high_temp), .any_alert(any_alert), .any_proc_ctrl(any_proc_ctrl),
    .ctrl_proc_ctrl(ctrl_proc_ctrl), .ctrl_purging(ctrl_purging),
    .nc_contact_closed(nc_contact_closed), .no_contact_closed(no_contact_closed));

// ===== testbench/srm_status_panel.sv
// Site status panel wired to both contacts: a run lamp and an alarm loop.
// Assumes the lamp is fed through the N.O. contact and the loop through the N.C. one.
module srm_status_panel (
    input  wire logic nc_contact_closed,
    input  wire logic no_contact_closed,
    output logic      run_lamp,
    output logic      alarm_lamp
);
    timeunit 1ns;
    timeprecision 1ps;
    // The alarm lamp lights when the normally closed loop is broken.
    assign run_lamp   = no_contact_closed;
    assign alarm_lamp = !nc_contact_closed;
endmodule : srm_status_panel

// ===== testbench/tb_status_relay_mode_logic.sv
// Self-checking bench for the relay mode logic with a status panel on the contacts.
// Assumes srm_pkg, srm_relay, the panel and the bound checker are compiled first.
module tb_status_relay_mode_logic import srm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic        pready, pslverr, nc_contact_closed, no_contact_closed, lamp_on, alarm_on, err;
    logic        any_running = 1'h0, any_high_temp = 1'h0, any_alert = 1'h0;
    logic        any_proc_ctrl = 1'h0, ctrl_proc_ctrl = 1'h0, ctrl_purging = 1'h0;
    logic [15:0] temp_value = 16'h0, input_value = 16'h0;
    int          n_errors = 0, checked = 0;
    always #10 mclk = ~mclk;
    srm_relay DUT (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .any_running(any_running), .any_high_temp(any_high_temp), .any_alert(any_alert),
        .any_proc_ctrl(any_proc_ctrl), .ctrl_proc_ctrl(ctrl_proc_ctrl),
        .ctrl_purging(ctrl_purging), .temp_value(temp_value), .input_value(input_value),
        .nc_contact_closed(nc_contact_closed), .no_contact_closed(no_contact_closed));
    srm_status_panel u_panel (.nc_contact_closed(nc_contact_closed),
        .no_contact_closed(no_contact_closed), .run_lamp(lamp_on), .alarm_lamp(alarm_on));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        do @(posedge mclk); while (pready !== 1'h1);
        r = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic set_flags(input logic [5:0] f);
        {any_running, any_high_temp, any_alert, any_proc_ctrl, ctrl_proc_ctrl,
            ctrl_purging} <= f;
    endtask : set_flags
    task automatic settle;
        repeat (6) @(posedge mclk);
        @(negedge mclk);
    endtask : settle
    task automatic contacts(input logic act);
        settle();
        chk({28'h0, nc_contact_closed, no_contact_closed, lamp_on, alarm_on},
            {28'h0, !act, act, act, act});
        @(posedge mclk);
    endtask : contacts
    task automatic t_regs;
        logic [31:0] rv [5] = '{32'h0, 32'hFFFF, 32'h0, 32'hFFFF, 32'h0};
        for (int i = 0; i < 5; i++) begin
            apb(1'h0, 12'(4 * i), 32'h0);
            chk(r, rv[i]);
            chk({31'h0, err}, 32'h0);
        end
        apb(1'h1, 12'h018, 32'h11);
        chk({31'h0, err}, 32'h1);
        apb(1'h0, 12'h018, 32'h0);
        chk(r, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'h0, 12'h000, 32'h0);
        chk(r, 32'h0);
    endtask : t_regs
    task automatic t_flag_modes;
        logic [3:0] codes [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8};
        for (int i = 0; i < 6; i++) begin
            apb(1'h1, 12'h000, {24'h0, codes[i], codes[i]});
            for (int v = 0; v < 2; v++) begin
                set_flags(v ? (6'h20 >> i) : ~(6'h20 >> i));
                contacts(v[0] ^ (codes[i] == 4'h3));
            end
        end
    endtask : t_flag_modes
    task automatic t_disabled;
        apb(1'h1, 12'h000, 32'h90);
        set_flags(6'h3F);
        contacts(1'h0);
    endtask : t_disabled
    task automatic t_split;
        apb(1'h1, 12'h000, 32'h81);
        set_flags(6'h20);
        settle();
        chk({30'h0, nc_contact_closed, no_contact_closed}, 32'h0);
        @(posedge mclk);
        set_flags(6'h01);
        settle();
        chk({30'h0, nc_contact_closed, no_contact_closed}, 32'h3);
    endtask : t_split
    task automatic t_reset;
        @(posedge mclk);
        rst <= 1'h1;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        chk({30'h0, nc_contact_closed, no_contact_closed}, 32'h2);
        @(posedge mclk);
        rst <= 1'h0;
        apb(1'h0, 12'h000, 32'h0);
        chk(r, 32'h0);
        contacts(1'h0);
    endtask : t_reset
    task automatic t_trip;
        logic [15:0] vals [6] = '{16'h64, 16'h65, 16'h5F, 16'h5A, 16'h59, 16'h65};
        logic [5:0]  hit = 6'h2E;
        for (int k = 0; k < 2; k++) begin
            apb(1'h1, k ? 12'h00C : 12'h004, 32'h64);
            apb(1'h1, k ? 12'h010 : 12'h008, 32'hA);
            apb(1'h1, 12'h000, k ? 32'h77 : 32'h66);
            for (int i = 0; i < 6; i++) begin
                if (k)
                    input_value <= vals[i];
                else
                    temp_value <= vals[i];
                contacts(hit[i]);
            end
            apb(1'h0, k ? 12'h00C : 12'h004, 32'h0);
            chk(r, 32'h64);
            apb(1'h0, 12'h014, 32'h0);
            chk(r, k ? 32'hF : 32'h7);
        end
    endtask : t_trip
    task automatic end_sim;
        if (n_errors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim
    initial begin
        repeat (20) @(posedge mclk);
        chk({30'h0, nc_contact_closed, no_contact_closed}, 32'h2);
        rst <= 1'h0;
        t_regs();
        t_flag_modes();
        t_disabled();
        t_split();
        t_trip();
        t_reset();
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        end_sim();
    end
endmodule : tb_status_relay_mode_logic
